// ---- verilog/fsf_regs.vh ----
`ifndef FSF_REGS_VH
`define FSF_REGS_VH

// ****************************************
// geometry
// ****************************************
`define FSF_DATA_W 18
`define FSF_DEPTH 8192

// ****************************************
// register byte addresses
// ****************************************
`define FSF_CTRL_ADDR 12'h000
`define FSF_FULL_OFS_ADDR 12'h004
`define FSF_EMPTY_OFS_ADDR 12'h008
`define FSF_STATUS_ADDR 12'h00C

// ****************************************
// field positions
// ****************************************
`define FSF_CTRL_MSTRST_BIT 0
`define FSF_CTRL_DATARST_BIT 1
`define FSF_CTRL_MODE_BIT 2
`define FSF_CTRL_LDSEL_BIT 3
`define FSF_ST_EMPTY_BIT 0
`define FSF_ST_FULL_BIT 1
`define FSF_ST_ALMFULL_BIT 2
`define FSF_ST_ALMEMPTY_BIT 3
`define FSF_ST_HALF_BIT 4
`define FSF_ST_OUTV_BIT 5
`define FSF_ST_CNT_LSB 16

// ****************************************
// reset values
// ****************************************
`define FSF_OFS_DEF_LO 16'h007F
`define FSF_OFS_DEF_HI 16'h03FF

// ****************************************
// timing
// ****************************************
`define FSF_CLK_NS 20
`define FSF_FWL_TF_MULT 10
`define FSF_FWL_STD_RCLK 2
`define FSF_FWL_FALL_RCLK 3

`endif

// ---- verilog/fsf_pin_sync.v ----
`timescale 1ns/100ps
module fsf_pin_sync #(
  parameter WIDTH = 1,
  parameter [0:0] RESET_VAL = 1'b0
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // pins in, filtered levels out
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] levelOut
);

reg [WIDTH-1:0] stage1_reg;
reg [WIDTH-1:0] stage2_reg;
reg [WIDTH-1:0] stage3_reg;
integer i;

// stage1 only feeds stage2; the vote uses stages two and three
always @(posedge ref_clk) begin
  if (!nrst) begin
    stage1_reg <= {WIDTH{RESET_VAL}};
    stage2_reg <= {WIDTH{RESET_VAL}};
    stage3_reg <= {WIDTH{RESET_VAL}};
    levelOut <= {WIDTH{RESET_VAL}};
  end else begin
    stage1_reg <= pinIn;
    stage2_reg <= stage1_reg;
    stage3_reg <= stage2_reg;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (stage2_reg[i] == stage3_reg[i]) begin
        levelOut[i] <= stage3_reg[i];
      end
    end
  end
end

endmodule // fsf_pin_sync

// ---- verilog/fsf_flag_logic.v ----
`timescale 1ns/100ps
`include "fsf_regs.vh"

//Contract
// - standard mode: empty flag low when no words; reads ignored while low.
// - standard first-word empty-flag rise within 10*Tf plus 2 read periods.
// - fall-through: output-ready low in the cycle the first word appears.
// - fall-through: output-ready high after last word read; reads then ignored.
// - fall-through first-word output-ready within 10*Tf plus 3 read periods.
// - empty/output-ready made on read side, two register stages.
// - almost-full low when count reaches depth minus full offset m.
// - master reset loads full offset 07FH or 3FFH by offset-load select.
// - full offset accepts any value from zero to depth minus one.
// - standard mode: almost-full low after depth minus m writes.
// - fall-through: almost-full low after depth plus one minus m writes.
// - reads ignored until empty indication shows data, whatever almost flags do.
// - almost-full updated on write side and double-registered.
// - almost-empty low when count falls to empty offset n.
// - master reset loads empty offset 07FH or 3FFH by offset-load select.
// - empty offset accepts any value from zero to depth minus one.
// - standard mode: almost-empty high after n plus one writes.
// - fall-through: almost-empty high after n plus two writes.
// - almost-empty updated on read side and double-registered.
// - word in the output register never counts as a memory word.
// - output-ready high after reset, low on first word, high on last read.
// - full after depth writes standard, one more in fall-through.
// - half-full low after depth/2+1 writes standard, depth/2+2 fall-through.
module fsf_flag_logic #(
  parameter DEPTH = `FSF_DEPTH,
  parameter DATA_W = `FSF_DATA_W
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // device pins
  input wire masterResetN,
  input wire partialResetN,
  input wire offsetLoadSelectN,
  input wire fallThroughMode,
  // write port
  input wire wrEn,
  input wire [DATA_W-1:0] wrData,
  // read port
  input wire rdEn,
  output reg [DATA_W-1:0] dataOut,
  // flags
  output reg emptyFlagN,
  output reg fullFlagN,
  output reg almostFullFlagN,
  output reg almostEmptyFlagN,
  output reg halfFullFlagN
);

// ****************************************
// geometry
// ****************************************
function integer clog2;
  input integer value;
  integer v;
  begin
    v = value - 1;
    clog2 = 0;
    while (v > 0) begin
      v = v >> 1;
      clog2 = clog2 + 1;
    end
  end
endfunction

localparam ADDR_W = clog2(DEPTH);
localparam CNT_W = ADDR_W + 1;
localparam [31:0] DEPTH32 = DEPTH;
localparam [CNT_W-1:0] DEPTH_C = DEPTH32[CNT_W-1:0];
localparam [CNT_W-1:0] HALF_C = DEPTH32[CNT_W:1];
localparam [15:0] OFS_LO = `FSF_OFS_DEF_LO;
localparam [15:0] OFS_HI = `FSF_OFS_DEF_HI;
// worst-case first-word figures, fast clock equal to this clock
localparam FWL_STD_NS = `FSF_FWL_TF_MULT * `FSF_CLK_NS + `FSF_FWL_STD_RCLK * `FSF_CLK_NS;
localparam FWL_FALL_NS = `FSF_FWL_TF_MULT * `FSF_CLK_NS + `FSF_FWL_FALL_RCLK * `FSF_CLK_NS;
localparam FWL_STD_CYC = FWL_STD_NS / `FSF_CLK_NS;
localparam FWL_FALL_CYC = FWL_FALL_NS / `FSF_CLK_NS;

// words between pointers; pointers carry one wrap bit
function [CNT_W-1:0] ptrDiff;
  input [CNT_W-1:0] ahead;
  input [CNT_W-1:0] behind;
  begin
    ptrDiff = ahead - behind;
  end
endfunction

// ****************************************
// pin synchronisers
// ****************************************
wire [3:0] pinLevel;

// reset level of the master reset pin is "asserted", so the block
// sits in master reset until the pin is seen high after nrst
fsf_pin_sync #(
  .WIDTH(1),
  .RESET_VAL(1'b0)
) uMstRstSync (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .pinIn(masterResetN),
  .levelOut(pinLevel[0])
);

fsf_pin_sync #(
  .WIDTH(3),
  .RESET_VAL(1'b0)
) uPinSync (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .pinIn({fallThroughMode, offsetLoadSelectN, partialResetN}),
  .levelOut(pinLevel[3:1])
);

// mode and select syncs reset to standard and low offsets, so a
// standard-mode start shows no stray flag edge after nrst
wire mstRstPinN = pinLevel[0];
wire dataRstPinN = pinLevel[1];
wire ldSelN = pinLevel[2];
wire ftPin = ~pinLevel[3] ? 1'b0 : 1'b1;

// ****************************************
// state
// ****************************************
reg [DATA_W-1:0] mem [0:DEPTH-1];
reg [CNT_W-1:0] wrPtr_reg;
reg [CNT_W-1:0] rdPtr_reg;
reg [CNT_W-1:0] wrPtrS1_reg;
reg [CNT_W-1:0] wrPtrS2_reg;
reg [CNT_W-1:0] rdPtrS1_reg;
reg [CNT_W-1:0] rdPtrS2_reg;
reg [ADDR_W-1:0] fullOfs_reg;
reg [ADDR_W-1:0] emptyOfs_reg;
reg mode_reg;
reg outValid_reg;
reg cmdMstRst_reg;
reg cmdDataRst_reg;
reg mstRstHold_reg;
reg fullS1_reg;
reg almFullS1_reg;
reg halfS1_reg;
reg almEmptyS1_reg;

// held one edge past the pin, so mode and offsets are taken from
// settled pin levels, not from the syncs' reset values
wire mstRstAct = ~mstRstPinN | mstRstHold_reg | cmdMstRst_reg;
wire clrData = mstRstAct | ~dataRstPinN | cmdDataRst_reg;
wire modeNow = mstRstAct ? ftPin : mode_reg;

// the word in the output register is already past rdPtr
wire [CNT_W-1:0] wrCnt = ptrDiff(wrPtr_reg, rdPtrS2_reg);
wire [CNT_W-1:0] rdCnt = ptrDiff(wrPtrS2_reg, rdPtr_reg);
wire [CNT_W-1:0] fullOfsW = {1'b0, fullOfs_reg};
wire [CNT_W-1:0] emptyOfsW = {1'b0, emptyOfs_reg};

// ****************************************
// write side
// ****************************************
wire wrGo = wrEn & (wrCnt != DEPTH_C) & ~clrData;

always @(posedge ref_clk) begin
  if (wrGo) begin
    mem[wrPtr_reg[ADDR_W-1:0]] <= wrData;
  end
end

always @(posedge ref_clk) begin
  if (!nrst || clrData) begin
    wrPtr_reg <= {CNT_W{1'b0}};
    rdPtrS1_reg <= {CNT_W{1'b0}};
    rdPtrS2_reg <= {CNT_W{1'b0}};
  end else begin
    if (wrGo) begin
      wrPtr_reg <= wrPtr_reg + 1'b1;
    end
    rdPtrS1_reg <= rdPtr_reg;
    rdPtrS2_reg <= rdPtrS1_reg;
  end
end

// write-side flags: first stage from the count, second stage drives pins
always @(posedge ref_clk) begin
  if (!nrst || clrData) begin
    fullS1_reg <= ~modeNow;
    fullFlagN <= ~modeNow;
    almFullS1_reg <= 1'b1;
    almostFullFlagN <= 1'b1;
    halfS1_reg <= 1'b1;
    halfFullFlagN <= 1'b1;
  end else begin
    // standard: low when full; fall-through: high when no space
    fullS1_reg <= mode_reg ? (wrCnt == DEPTH_C) : (wrCnt != DEPTH_C);
    fullFlagN <= fullS1_reg;
    almFullS1_reg <= ~(wrCnt >= DEPTH_C - fullOfsW);
    almostFullFlagN <= almFullS1_reg;
    halfS1_reg <= ~(wrCnt > HALF_C);
    halfFullFlagN <= halfS1_reg;
  end
end

// ****************************************
// read side
// ****************************************
// write pointer reaches the read side through two stages
always @(posedge ref_clk) begin
  if (!nrst || clrData) begin
    wrPtrS1_reg <= {CNT_W{1'b0}};
    wrPtrS2_reg <= {CNT_W{1'b0}};
  end else begin
    wrPtrS1_reg <= wrPtr_reg;
    wrPtrS2_reg <= wrPtrS1_reg;
  end
end

// a standard read needs the flag high and a word really present
wire stdRdGo = ~mode_reg & rdEn & emptyFlagN & (rdCnt != {CNT_W{1'b0}});
// fall-through moves a word when the output register is free or being read
wire ftShift = mode_reg & (~outValid_reg | rdEn);
wire ftLoad = ftShift & (rdCnt != {CNT_W{1'b0}});

always @(posedge ref_clk) begin
  if (!nrst) begin
    rdPtr_reg <= {CNT_W{1'b0}};
    outValid_reg <= 1'b0;
    emptyFlagN <= 1'b0;
    dataOut <= {DATA_W{1'b0}};
  end else if (clrData) begin
    rdPtr_reg <= {CNT_W{1'b0}};
    outValid_reg <= 1'b0;
    emptyFlagN <= modeNow;
  end else if (mode_reg) begin
    if (ftLoad) begin
      // data and flag change on the same edge
      dataOut <= mem[rdPtr_reg[ADDR_W-1:0]];
      rdPtr_reg <= rdPtr_reg + 1'b1;
      outValid_reg <= 1'b1;
      emptyFlagN <= 1'b0;
    end else if (ftShift && outValid_reg) begin
      // last word taken; further reads do nothing until a new load
      outValid_reg <= 1'b0;
      emptyFlagN <= 1'b1;
    end
  end else begin
    if (stdRdGo) begin
      dataOut <= mem[rdPtr_reg[ADDR_W-1:0]];
      rdPtr_reg <= rdPtr_reg + 1'b1;
      emptyFlagN <= (rdCnt != {{(CNT_W-1){1'b0}}, 1'b1});
    end else begin
      emptyFlagN <= (rdCnt != {CNT_W{1'b0}});
    end
  end
end

// almost-empty compares memory words only against n
always @(posedge ref_clk) begin
  if (!nrst || clrData) begin
    almEmptyS1_reg <= 1'b0;
    almostEmptyFlagN <= 1'b0;
  end else begin
    almEmptyS1_reg <= (rdCnt > emptyOfsW);
    almostEmptyFlagN <= almEmptyS1_reg;
  end
end

// ****************************************
// mode and offsets
// ****************************************
wire apbAccess = psel & penable;
wire apbWrite = apbAccess & pwrite;
wire hitCtrl = (paddr == `FSF_CTRL_ADDR);
wire hitFull = (paddr == `FSF_FULL_OFS_ADDR);
wire hitEmpty = (paddr == `FSF_EMPTY_OFS_ADDR);
wire hitStatus = (paddr == `FSF_STATUS_ADDR);
wire hitAny = hitCtrl | hitFull | hitEmpty | hitStatus;

always @(posedge ref_clk) begin
  if (!nrst) begin
    mode_reg <= 1'b0;
    fullOfs_reg <= OFS_LO[ADDR_W-1:0];
    emptyOfs_reg <= OFS_LO[ADDR_W-1:0];
  end else if (mstRstAct) begin
    // partial reset leaves mode and offsets alone
    mode_reg <= ftPin;
    fullOfs_reg <= ldSelN ? OFS_HI[ADDR_W-1:0] : OFS_LO[ADDR_W-1:0];
    emptyOfs_reg <= ldSelN ? OFS_HI[ADDR_W-1:0] : OFS_LO[ADDR_W-1:0];
  end else begin
    // every value 0..DEPTH-1 fits the field exactly
    if (apbWrite && hitFull) begin
      fullOfs_reg <= pwdata[ADDR_W-1:0];
    end
    if (apbWrite && hitEmpty) begin
      emptyOfs_reg <= pwdata[ADDR_W-1:0];
    end
  end
end

// software reset commands last one cycle
always @(posedge ref_clk) begin
  if (!nrst) begin
    cmdMstRst_reg <= 1'b0;
    cmdDataRst_reg <= 1'b0;
    mstRstHold_reg <= 1'b1;
  end else begin
    cmdMstRst_reg <= apbWrite & hitCtrl & pwdata[`FSF_CTRL_MSTRST_BIT];
    cmdDataRst_reg <= apbWrite & hitCtrl & pwdata[`FSF_CTRL_DATARST_BIT];
    mstRstHold_reg <= ~mstRstPinN;
  end
end

// ****************************************
// apb slave
// ****************************************
// zero wait states; read data is captured in the setup cycle
assign pready = 1'b1;
assign pslverr = apbAccess & ~hitAny;

reg [31:0] rdMux;

always @* begin
  rdMux = 32'h00000000;
  if (hitCtrl) begin
    rdMux[`FSF_CTRL_MODE_BIT] = mode_reg;
    rdMux[`FSF_CTRL_LDSEL_BIT] = ldSelN;
  end else if (hitFull) begin
    rdMux[ADDR_W-1:0] = fullOfs_reg;
  end else if (hitEmpty) begin
    rdMux[ADDR_W-1:0] = emptyOfs_reg;
  end else if (hitStatus) begin
    rdMux[`FSF_ST_EMPTY_BIT] = emptyFlagN;
    rdMux[`FSF_ST_FULL_BIT] = fullFlagN;
    rdMux[`FSF_ST_ALMFULL_BIT] = almostFullFlagN;
    rdMux[`FSF_ST_ALMEMPTY_BIT] = almostEmptyFlagN;
    rdMux[`FSF_ST_HALF_BIT] = halfFullFlagN;
    rdMux[`FSF_ST_OUTV_BIT] = outValid_reg;
    rdMux[`FSF_ST_CNT_LSB+CNT_W-1:`FSF_ST_CNT_LSB] = wrCnt;
  end
end

always @(posedge ref_clk) begin
  if (!nrst) begin
    prdata <= 32'h00000000;
  end else if (psel && !penable) begin
    prdata <= pwrite ? 32'h00000000 : rdMux;
  end
end

endmodule // fsf_flag_logic

// ---- bench/fsf_flag_logic_asserts.sv ----
`timescale 1ns/100ps
module fsf_flag_logic_asserts #(
  parameter DATA_W = 18
) (
  // watched ports
  input wire ref_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire masterResetN,
  input wire fallThroughMode,
  input wire wrEn,
  input wire rdEn,
  input wire [DATA_W-1:0] dataOut,
  input wire emptyFlagN,
  input wire fullFlagN,
  input wire almostFullFlagN,
  input wire almostEmptyFlagN,
  input wire halfFullFlagN
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire [4:0] flags = {fullFlagN, almostFullFlagN, halfFullFlagN, almostEmptyFlagN, emptyFlagN};
  // mode pin is only moved under master reset, so it stands for the mode
  wire isStd = !fallThroughMode;
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_slverr; psel && penable && paddr > 12'h00C |-> pslverr; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped without error");
  property p_rst; $rose(nrst) |-> flags == 5'h1C; endproperty
  a_rst: assert property (p_rst) else $error("flags wrong after reset");
  property p_rdign; rdEn && !emptyFlagN && isStd |=> $stable(dataOut); endproperty
  a_rdign: assert property (p_rdign) else $error("read taken while empty");
  property p_fwlstd; wrEn && !emptyFlagN && isStd && masterResetN |-> ##[1:12] emptyFlagN; endproperty
  a_fwlstd: assert property (p_fwlstd) else $error("first word late");
  property p_fwlft; wrEn && emptyFlagN && !isStd && masterResetN |-> ##[1:13] !emptyFlagN; endproperty
  a_fwlft: assert property (p_fwlft) else $error("output ready late");
  property p_rise; $rose(emptyFlagN) && isStd |-> $past(wrEn, 4); endproperty
  a_rise: assert property (p_rise) else $error("flag rose without write");
  property p_fullpaf; !fullFlagN && isStd |-> !almostFullFlagN; endproperty
  a_fullpaf: assert property (p_fullpaf) else $error("full but not almost full");
endmodule // fsf_flag_logic_asserts

bind fsf_flag_logic fsf_flag_logic_asserts #(.DATA_W(DATA_W)) u_fsf_flag_logic_asserts (.ref_clk, .nrst,
  .psel, .penable, .paddr, .pready, .pslverr, .masterResetN, .fallThroughMode, .wrEn, .rdEn, .dataOut,
  .emptyFlagN, .fullFlagN, .almostFullFlagN, .almostEmptyFlagN, .halfFullFlagN);

// ---- bench/fsf_stream_model.sv ----
`timescale 1ns/100ps
module fsf_stream_model (
  // control
  input wire ref_clk,
  input wire [31:0] wrTarget,
  input wire rdGo,
  input wire fallThroughMode,
  input wire emptyFlagN,
  // stream
  output logic wrEn = 1'b0,
  output logic rdEn = 1'b0,
  output logic [31:0] sent = 32'h0,
  output wire [17:0] wrData
);
  assign wrData = sent[17:0];
  always @(posedge ref_clk) begin
    sent <= sent + {31'h0, wrEn};
    // counts the word in flight so the last lands exactly on target
    wrEn <= (sent + {31'h0, wrEn}) < wrTarget;
    // flag is seen a cycle late, so one stray read follows the last
    rdEn <= rdGo && (emptyFlagN ^ fallThroughMode);
  end
endmodule // fsf_stream_model

// ---- bench/fsf_flag_logic_test.sv ----
`timescale 1ns/100ps
module fsf_flag_logic_test;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic e;} fsf_row_t;
  logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rdGo = 1'b0, er;
  logic masterResetN = 1'b1, partialResetN = 1'b1, offsetLoadSelectN = 1'b0, fallThroughMode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, wrTarget = 32'h0, rd;
  wire [31:0] prdata, sent;
  wire pready, pslverr, wrEn, rdEn, emptyFlagN, fullFlagN, almostFullFlagN, almostEmptyFlagN, halfFullFlagN;
  wire [17:0] wrData, dataOut;
  wire [31:0] fl = {27'h0, fullFlagN, almostFullFlagN, halfFullFlagN, almostEmptyFlagN, emptyFlagN};
  int num_errors = 0, tests_run = 0, i, j, base;
  fsf_row_t rows[11] = '{'{12'h004, 1'b0, 32'h7F, 1'b0}, '{12'h008, 1'b0, 32'h7F, 1'b0},
    '{12'h004, 1'b1, 32'h1FFF, 1'b0}, '{12'h004, 1'b0, 32'h1FFF, 1'b0}, '{12'h008, 1'b1, 32'h0, 1'b0},
    '{12'h008, 1'b0, 32'h0, 1'b0}, '{12'h004, 1'b1, 32'h4, 1'b0}, '{12'h008, 1'b1, 32'h2, 1'b0},
    '{12'h008, 1'b0, 32'h2, 1'b0}, '{12'h010, 1'b0, 32'h0, 1'b1}, '{12'h014, 1'b1, 32'h5, 1'b1}};
  int stdN[9] = '{1, 2, 3, 4096, 4097, 8187, 8188, 8192, 8193};
  logic [31:0] stdF[9] = '{32'h1D, 32'h1D, 32'h1F, 32'h1F, 32'h1B, 32'h1B, 32'h13, 32'h03, 32'h03};
  int ftN[7] = '{1, 1024, 1025, 7169, 7170, 8192, 8193};
  logic [31:0] ftF[7] = '{32'h0C, 32'h0C, 32'h0E, 32'h0A, 32'h02, 32'h02, 32'h12};

  fsf_flag_logic u_fsf_flag_logic (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .masterResetN, .partialResetN, .offsetLoadSelectN, .fallThroughMode, .wrEn, .wrData,
    .rdEn, .dataOut, .emptyFlagN, .fullFlagN, .almostFullFlagN, .almostEmptyFlagN, .halfFullFlagN);
  fsf_stream_model u_fsf_stream_model (.ref_clk, .wrTarget, .rdGo, .fallThroughMode, .emptyFlagN,
    .wrEn, .rdEn, .sent, .wrData);

  // ********************
  // tasks
  // ********************
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task waitE(input logic lvl);
    for (j = 0; j < 20000 && emptyFlagN !== lvl; j++) @(posedge ref_clk);
  endtask
  task fillTo(input int k);
    wrTarget <= k;
    @(posedge ref_clk);
    for (j = 0; j < 20000 && sent != k; j++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
  endtask
  // bench edge is two before the write edge; a flag is seen one edge late
  task fwl(input logic lvl, input int lim);
    wrTarget <= sent + 1;
    waitE(lvl);
    chk("latency", 32'h1, {31'h0, j <= lim});
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    results;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("flags", 32'h1C, fl);
    foreach (rows[k]) begin
      apb(rows[k].a, rows[k].w, rows[k].d);
      if (!rows[k].w) chk("prdata", rows[k].d, rd);
      chk("pslverr", {31'h0, rows[k].e}, {31'h0, er});
    end
    fwl(1'b1, 15);
    for (i = 0; i < 9; i++) begin
      fillTo(stdN[i]);
      chk("flags", stdF[i], fl);
    end
    rdGo <= 1'b1;
    waitE(1'b0);
    repeat (8) @(posedge ref_clk);
    chk("dataOut", 32'h1FFF, {14'h0, dataOut});
    chk("flags", 32'h1C, fl);
    rdGo <= 1'b0;
    fallThroughMode <= 1'b1;
    offsetLoadSelectN <= 1'b1;
    masterResetN <= 1'b0;
    repeat (8) @(posedge ref_clk);
    masterResetN <= 1'b1;
    repeat (8) @(posedge ref_clk);
    for (i = 4; i < 12; i += 4) begin
      apb(i[11:0], 1'b0, 32'h0);
      chk("offset", 32'h3FF, rd);
    end
    chk("flags", 32'h0D, fl);
    base = sent;
    fwl(1'b0, 16);
    chk("dataOut", base, {14'h0, dataOut});
    for (i = 0; i < 7; i++) begin
      fillTo(base + ftN[i]);
      chk("flags", ftF[i], fl);
    end
    apb(12'h000, 1'b1, 32'h2);
    repeat (8) @(posedge ref_clk);
    chk("flags", 32'h0D, fl);
    fwl(1'b0, 16);
    rdGo <= 1'b1;
    waitE(1'b1);
    repeat (8) @(posedge ref_clk);
    chk("flags", 32'h0D, fl);
    apb(12'h000, 1'b1, 32'h1);
    repeat (8) @(posedge ref_clk);
    apb(12'h000, 1'b0, 32'h0);
    chk("ctrl", 32'h0000000C, rd);
    chk("flags", 32'h0D, fl);
    results;
  end
endmodule // fsf_flag_logic_test
